//--- attr_pkg.sv
// Purpose: shared constants and carriers for the attribute palette stage
// Assumes: 8-bit host i/o data, 4-bit pixel samples from the pipeline
// Notes: port addresses are 16-bit i/o addresses
package attr_pkg;

    // host i/o port addresses
    localparam logic [15:0] PORT_ATTR_WR    = 16'h03C0;
    localparam logic [15:0] PORT_ATTR_RD    = 16'h03C1;
    localparam logic [15:0] PORT_STAT_MONO  = 16'h03BA;
    localparam logic [15:0] PORT_STAT_COLOR = 16'h03DA;
    localparam logic [15:0] PORT_DAC_LO     = 16'h03C6;
    localparam logic [15:0] PORT_DAC_HI     = 16'h03C9;

    // indexed register numbers
    localparam logic [4:0] IDX_PAL_LAST = 5'h0F;
    localparam logic [4:0] IDX_MODE     = 5'h10;
    localparam logic [4:0] IDX_BORDER   = 5'h11;
    localparam logic [4:0] IDX_PLANE    = 5'h12;
    localparam logic [4:0] IDX_PAN      = 5'h13;
    localparam logic [4:0] IDX_CSEL     = 5'h14;

    // field positions
    localparam int IDX_SRC_BIT  = 5;
    localparam int MODE_GFX     = 0;
    localparam int MODE_MONO    = 1;
    localparam int MODE_LINEGFX = 2;
    localparam int MODE_BLINK   = 3;
    localparam int MODE_PANCMP  = 5;
    localparam int MODE_WIDE    = 6;
    localparam int MODE_P54SEL  = 7;

    // line-graphics character range
    localparam logic [7:0] LINE_GFX_LO = 8'hC0;
    localparam logic [7:0] LINE_GFX_HI = 8'hDF;

    // reset value, and the pan value that gives no shift in nine-dot modes
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [3:0] PAN_NINE_0 = 4'h8;

    // one dot from the display pipeline
    typedef struct packed {
        logic [3:0] planes;    // four plane bits of this dot
        logic [7:0] char_code; // character code, text modes
        logic [7:0] attr;      // character attribute, text modes
        logic       fg;        // font pixel, text modes
        logic       dot9;      // this dot is the ninth of the cell
        logic       de;        // display enable
        logic       blank;     // blanking
    } dot_s;

endpackage

//--- attr_fifo.sv
// Purpose: synchronous fifo for the dot stream
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact
`timescale 1ns/1ns
`default_nettype none
module attr_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    // handshake terms
    assign in_ready  = cnt_r < (AW+1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointers and storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

//--- attr_palette.sv
// Purpose: attribute stage mapping dot values through a 16-entry palette
// Assumes: host i/o strobes are one-cycle pulses in the clk domain
// Notes: clk is the dot clock; dac colour tables stay outside
`timescale 1ns/1ns
`default_nettype none
module attr_palette #(
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // host i/o port
    input  wire logic [15:0]         io_addr,
    input  wire logic                io_wr,
    input  wire logic                io_rd,
    input  wire logic [7:0]          io_wdata,
    output logic [7:0]               io_rdata,
    // display pipeline
    input  wire logic                dot_valid,
    output logic                     dot_ready,
    input  wire attr_pkg::dot_s      dot_in,
    input  wire logic                blink_phase,
    input  wire logic                line_compare,
    input  wire logic                vsync,
    // status port colour bits
    output logic [1:0]               status_colour,
    // external palette dac
    output logic [7:0]               colour_index,
    output logic                     palette_dac_read_strobe,
    output logic                     palette_dac_write_strobe,
    output logic [1:0]               dac_reg_sel,
    output logic [7:0]               dac_wdata
);
    localparam int DW = $bits(attr_pkg::dot_s);

    typedef struct packed {
        logic [15:0][5:0] pal;
        logic [7:0]       index;
        logic             toggle;
        logic [7:0]       mode;
        logic [7:0]       border;
        logic [7:0]       plane;
        logic [3:0]       pan;
        logic [3:0]       csel;
        logic             pan_zero;
        logic             half;
        logic [3:0]       low_nib;
        logic [7:0]       colour;
        logic [1:0]       status;
        logic [7:0]       rdata;
        logic             dac_rd;
        logic             dac_wr;
        logic [1:0]       dac_sel;
        logic [7:0]       dac_data;
        logic             last_fg;
        logic [7:0][3:0]  hist;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic          fv;
    logic          fr;
    attr_pkg::dot_s fd;

    // dot buffer between pipeline and palette
    attr_fifo #(.W(DW), .D(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (dot_valid),
        .in_ready  (dot_ready),
        .in_data   (dot_in),
        .out_valid (fv),
        .out_ready (fr),
        .out_data  (fd)
    );
    assign fr = 1'b1;

    // register read mux
    function automatic logic [7:0] reg_read(input state_s s);
        logic [4:0] i;
        i = s.index[4:0];
        if (i <= attr_pkg::IDX_PAL_LAST) reg_read = {2'b00, s.pal[i[3:0]]};
        else if (i == attr_pkg::IDX_MODE)   reg_read = s.mode;
        else if (i == attr_pkg::IDX_BORDER) reg_read = s.border;
        else if (i == attr_pkg::IDX_PLANE)  reg_read = s.plane;
        else if (i == attr_pkg::IDX_PAN)    reg_read = {4'h0, s.pan};
        else if (i == attr_pkg::IDX_CSEL)   reg_read = {4'h0, s.csel};
        else reg_read = 8'h00;
    endfunction

    // effective pan shift in pixels
    function automatic logic [3:0] pan_shift(input state_s s, input logic zero);
        logic       nine;
        nine = !s.mode[attr_pkg::MODE_GFX] && s.mode[attr_pkg::MODE_MONO];
        if (zero) pan_shift = 4'h0;
        else if (nine) pan_shift = (s.pan >= attr_pkg::PAN_NINE_0) ? 4'h0
                                   : s.pan + 4'h1;
        else if (s.mode[attr_pkg::MODE_WIDE]) pan_shift = {2'b00, s.pan[2:1]};
        else pan_shift = {1'b0, s.pan[2:0]};
    endfunction

    // next-state logic
    always_comb begin
        logic [3:0] v;
        logic [5:0] pe;
        logic [7:0] c;
        logic [3:0] sh;
        logic       in_lg;
        logic       acc;
        st_nxt        = st_r;
        st_nxt.dac_rd = 1'b0;
        st_nxt.dac_wr = 1'b0;
        v = 4'h0;
        pe = 6'h00;
        c = 8'h00;
        sh = 4'h0;
        in_lg = 1'b0;
        acc = 1'b0;
        // host side
        if (io_rd && (io_addr == attr_pkg::PORT_STAT_MONO
                      || io_addr == attr_pkg::PORT_STAT_COLOR)) begin
            st_nxt.toggle = 1'b0;
            st_nxt.rdata  = {2'b00, st_r.status, 4'h0};
        end
        if (io_rd && (io_addr == attr_pkg::PORT_ATTR_RD
                      || io_addr == attr_pkg::PORT_ATTR_WR)) begin
            st_nxt.rdata = (io_addr == attr_pkg::PORT_ATTR_WR) ? st_r.index
                           : reg_read(st_r);
        end
        if (io_wr && io_addr == attr_pkg::PORT_ATTR_WR) begin
            st_nxt.toggle = !st_r.toggle;
            if (!st_r.toggle) begin
                st_nxt.index = {2'b00, io_wdata[5:0]};
            end else begin
                case (st_r.index[4:0]) inside
                    [5'h00:5'h0F]: st_nxt.pal[st_r.index[3:0]] = io_wdata[5:0];
                    attr_pkg::IDX_MODE:   st_nxt.mode   = io_wdata;
                    attr_pkg::IDX_BORDER: st_nxt.border = io_wdata;
                    attr_pkg::IDX_PLANE:  st_nxt.plane  = io_wdata;
                    attr_pkg::IDX_PAN:    st_nxt.pan    = io_wdata[3:0];
                    attr_pkg::IDX_CSEL:   st_nxt.csel   = io_wdata[3:0];
                    default: ;
                endcase
            end
        end
        // dac port routing
        if (io_addr >= attr_pkg::PORT_DAC_LO && io_addr <= attr_pkg::PORT_DAC_HI) begin
            st_nxt.dac_rd   = io_rd;
            st_nxt.dac_wr   = io_wr;
            st_nxt.dac_sel  = io_addr[1:0] - 2'b10;
            st_nxt.dac_data = io_wdata;
        end
        // pan override: set by compare, cleared by vsync; the set wins if both come at once
        if (line_compare && st_r.mode[attr_pkg::MODE_PANCMP]) st_nxt.pan_zero = 1'b1;
        else if (vsync) st_nxt.pan_zero = 1'b0;
        // dot path
        if (fv) begin
            if (st_r.mode[attr_pkg::MODE_GFX]) begin
                v = fd.planes & st_r.plane[3:0];
            end else begin
                in_lg = fd.char_code >= attr_pkg::LINE_GFX_LO
                        && fd.char_code <= attr_pkg::LINE_GFX_HI;
                acc = fd.fg;
                if (fd.dot9) begin
                    acc = (st_r.mode[attr_pkg::MODE_LINEGFX] && st_r.mode[attr_pkg::MODE_MONO]
                           && in_lg) ? st_r.last_fg : 1'b0;
                end
                if (st_r.mode[attr_pkg::MODE_BLINK] && fd.attr[7] && blink_phase)
                    acc = 1'b0;
                v = acc ? fd.attr[3:0]
                    : {fd.attr[7] & !st_r.mode[attr_pkg::MODE_BLINK], fd.attr[6:4]};
                v = v & st_r.plane[3:0];
            end
            st_nxt.last_fg = acc;
            // eight-dot delay line; a larger pan takes a later dot, moving the image left
            st_nxt.hist = {st_r.hist[6:0], v};
            sh = pan_shift(st_r, st_r.pan_zero);
            v = (sh >= 4'h8) ? v : st_r.hist[3'(4'h7 - sh)];
            pe = st_r.index[attr_pkg::IDX_SRC_BIT] ? st_r.pal[v] : 6'h00;
            c[3:0] = pe[3:0];
            c[5:4] = st_r.mode[attr_pkg::MODE_P54SEL] ? st_r.csel[1:0] : pe[5:4];
            c[7:6] = st_r.csel[3:2];
            if (st_r.mode[attr_pkg::MODE_WIDE]) begin
                st_nxt.half = !st_r.half;
                if (!st_r.half) st_nxt.low_nib = pe[3:0];
                else st_nxt.colour = {st_r.low_nib, pe[3:0]};
            end else begin
                st_nxt.half   = 1'b0;
                st_nxt.colour = c;
            end
            if (fd.blank) st_nxt.colour = 8'h00;
            else if (!fd.de) st_nxt.colour = st_r.border;
            case (st_r.plane[5:4])
                2'b00:   st_nxt.status = {st_nxt.colour[2], st_nxt.colour[0]};
                2'b01:   st_nxt.status = st_nxt.colour[5:4];
                2'b10:   st_nxt.status = {st_nxt.colour[3], st_nxt.colour[1]};
                default: st_nxt.status = st_nxt.colour[7:6];
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) st_r <= '0;
        else st_r <= st_nxt;
    end

    // outputs straight from flops
    assign io_rdata                 = st_r.rdata;
    assign status_colour            = st_r.status;
    assign colour_index             = st_r.colour;
    assign palette_dac_read_strobe  = st_r.dac_rd;
    assign palette_dac_write_strobe = st_r.dac_wr;
    assign dac_reg_sel              = st_r.dac_sel;
    assign dac_wdata                = st_r.dac_data;

    // toggle must clear the cycle after a status read
    toggle_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_rd && io_addr == attr_pkg::PORT_STAT_COLOR |=> !st_r.toggle)
        else $error("toggle not cleared by status read");

    // write flips toggle
    toggle_flip_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && io_addr == attr_pkg::PORT_ATTR_WR && !(io_rd)
        |=> st_r.toggle != $past(st_r.toggle))
        else $error("toggle did not flip on write");

    // blank gives zero colour
    blank_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        fv && fd.blank |=> colour_index == 8'h00)
        else $error("colour not zero in blanking");

    // border shown outside display
    border_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        fv && !fd.blank && !fd.de |=> colour_index == $past(st_r.border))
        else $error("border colour not driven");

    // pan zero holds until vsync
    pan_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.pan_zero && !vsync |=> st_r.pan_zero)
        else $error("pan override dropped early");

    // dac strobe follows host access
    dac_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_wr && io_addr == attr_pkg::PORT_DAC_HI |=> palette_dac_write_strobe)
        else $error("dac write strobe missing");

    // data port read leaves toggle alone
    read_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_rd && !io_wr && io_addr == attr_pkg::PORT_ATTR_RD |=> $stable(st_r.toggle))
        else $error("data read changed toggle");

    // palette blocked while source bit clear
    src_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        fv && !fd.blank && fd.de && !st_r.index[attr_pkg::IDX_SRC_BIT]
        && !st_r.mode[attr_pkg::MODE_WIDE] && !st_r.mode[attr_pkg::MODE_P54SEL]
        |=> colour_index[5:0] == 6'h00)
        else $error("palette reached display while blocked");

    // the two halves of an attribute port write pair
    sequence idx_write_s;
        io_wr && !io_rd && io_addr == attr_pkg::PORT_ATTR_WR && !st_r.toggle;
    endsequence
    sequence pal_write_s;
        io_wr && !io_rd && io_addr == attr_pkg::PORT_ATTR_WR && st_r.toggle && !st_r.index[4];
    endsequence

    // first write of a pair loads the index
    index_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        idx_write_s |=> st_r.index[5:0] == $past(io_wdata[5:0]))
        else $error("index not loaded by first write");

    // second write of a pair loads the selected palette entry
    palette_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        pal_write_s |=> st_r.pal[$past(st_r.index[3:0])] == $past(io_wdata[5:0]))
        else $error("palette entry not loaded");

    // compare with compatibility on forces the pan to zero
    pan_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        line_compare && st_r.mode[attr_pkg::MODE_PANCMP] |=> st_r.pan_zero)
        else $error("line compare did not zero the pan");

    // vsync alone releases the pan override
    pan_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        vsync && !line_compare |=> !st_r.pan_zero)
        else $error("pan override not released by vsync");

    // dac read strobe follows host read
    dac_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
        io_rd && io_addr == attr_pkg::PORT_DAC_LO + 16'h0001 |=> palette_dac_read_strobe)
        else $error("dac read strobe missing");

    // status bits follow colour bits 5:4 when selected
    status_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        fv && st_r.plane[5:4] == 2'b01 |=> status_colour == colour_index[5:4])
        else $error("status colour bits wrong");
endmodule
`default_nettype wire

//--- dac_model.sv
// Purpose: behavioural palette dac at the far side of the attribute stage
// Assumes: dac strobes are active-high one-cycle pulses on clk
// Notes: counts host accesses so the bench can judge their routing
`timescale 1ns/1ns
`default_nettype none
module dac_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // from the attribute stage
    input  wire logic [7:0] colour_index,
    input  wire logic       palette_dac_read_strobe,
    input  wire logic       palette_dac_write_strobe,
    input  wire logic [1:0] dac_reg_sel,
    input  wire logic [7:0] dac_wdata,
    // seen by the bench, except shade, which the bench leaves open
    output logic [7:0]      wr_count,
    output logic [7:0]      rd_count,
    output logic [1:0]      last_sel,
    output logic [7:0]      last_data,
    output logic [7:0]      long_pulses,
    output logic [7:0]      shade
);
    logic [7:0] table_r [256];
    logic       wr_d_r;
    logic       rd_d_r;

    // the colour index only addresses the table held here
    assign shade = table_r[colour_index];

    // capture host accesses and flag strobes that last too long
    always @(posedge clk) begin
        if (!rst_n) begin
            wr_count    <= 8'h00;
            rd_count    <= 8'h00;
            last_sel    <= 2'b00;
            last_data   <= 8'h00;
            long_pulses <= 8'h00;
            wr_d_r      <= 1'b0;
            rd_d_r      <= 1'b0;
        end else begin
            wr_d_r <= palette_dac_write_strobe;
            rd_d_r <= palette_dac_read_strobe;
            if (palette_dac_write_strobe) begin
                wr_count           <= wr_count + 8'h01;
                last_sel           <= dac_reg_sel;
                last_data          <= dac_wdata;
                table_r[dac_wdata] <= ~dac_wdata;
            end
            if (palette_dac_read_strobe) begin
                rd_count <= rd_count + 8'h01;
                last_sel <= dac_reg_sel;
            end
            if ((wr_d_r && palette_dac_write_strobe) || (rd_d_r && palette_dac_read_strobe)) begin
                long_pulses <= long_pulses + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- attr_palette_tb.sv
// Purpose: self-checking bench for the attribute palette stage
// Assumes: one dot clock, host strobes one cycle wide
// Notes: blink phase stays low; the pan scenario pulses line compare and vsync
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module attr_palette_tb;
    logic                 clk          = 1'b0;
    logic                 rst_n        = 1'b0;
    logic [15:0]          io_addr      = 16'h0000;
    logic                 io_wr        = 1'b0;
    logic                 io_rd        = 1'b0;
    logic [7:0]           io_wdata     = 8'h00;
    logic                 dot_valid    = 1'b0;
    attr_pkg::dot_s       dot_in       = '0;
    logic                 blink_phase  = 1'b0;
    logic                 line_compare = 1'b0;
    logic                 vsync        = 1'b0;
    logic [7:0]           io_rdata, colour_index, dac_wdata, v;
    logic                 dot_ready, rd_s, wr_s;
    logic [1:0]           status_colour, dac_reg_sel, last_sel;
    logic [7:0]           wr_count, rd_count, last_data, long_pulses;
    int                   err_total    = 0;
    int                   checked      = 0;
    localparam logic [7:0] RV [5] = '{8'hAD, 8'h5A, 8'h35, 8'h07, 8'h0E};
    localparam logic [1:0] ST [4] = '{2'b00, 2'b01, 2'b11, 2'b01};

    // dot clock, 100 ns period
    always #50 clk = ~clk;

    // design and far-side dac
    attr_palette #(.FIFO_DEPTH(32)) i_attr_palette (.clk(clk), .rst_n(rst_n),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .dot_valid(dot_valid), .dot_ready(dot_ready), .dot_in(dot_in),
        .blink_phase(blink_phase), .line_compare(line_compare), .vsync(vsync),
        .status_colour(status_colour), .colour_index(colour_index),
        .palette_dac_read_strobe(rd_s), .palette_dac_write_strobe(wr_s),
        .dac_reg_sel(dac_reg_sel), .dac_wdata(dac_wdata));
    dac_model i_dac_model (.clk(clk), .rst_n(rst_n), .colour_index(colour_index),
        .palette_dac_read_strobe(rd_s), .palette_dac_write_strobe(wr_s),
        .dac_reg_sel(dac_reg_sel), .dac_wdata(dac_wdata), .wr_count(wr_count),
        .rd_count(rd_count), .last_sel(last_sel), .last_data(last_data),
        .long_pulses(long_pulses), .shade());

    // host bus cycles: one-cycle strobes, data read after the answer edge
    task automatic io_w(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask
    task automatic io_r(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        @(negedge clk);
        d = io_rdata;
    endtask
    // index byte: display source bit set except while on palette entries
    function automatic logic [7:0] ix(input logic [4:0] r);
        return {2'b00, r > attr_pkg::IDX_PAL_LAST, r};
    endfunction
    function automatic logic [7:0] pal(input int i);
        return 8'h10 + {3'b000, 4'(i), 1'b0};
    endfunction
    task automatic set_reg(input logic [4:0] r, input logic [7:0] d);
        io_r(attr_pkg::PORT_STAT_COLOR, v);
        io_w(attr_pkg::PORT_ATTR_WR, ix(r));
        io_w(attr_pkg::PORT_ATTR_WR, d);
    endtask
    task automatic get_reg(input logic [4:0] r, output logic [7:0] d);
        io_r(attr_pkg::PORT_STAT_COLOR, d);
        io_w(attr_pkg::PORT_ATTR_WR, ix(r));
        io_r(attr_pkg::PORT_ATTR_RD, d);
    endtask
    // hand one dot to the fifo, held until taken
    task automatic push(input logic [3:0] p, input logic de, input logic bl);
        @(posedge clk);
        dot_in    <= '{planes: p, char_code: 8'h00, attr: 8'h00, fg: 1'b0, dot9: 1'b0,
                       de: de, blank: bl};
        dot_valid <= 1'b1;
        do @(posedge clk); while (dot_ready !== 1'b1);
        dot_valid <= 1'b0;
    endtask
    // blank dot first, then the dot under test; returns the colour it gives
    task automatic show(input logic [3:0] p, input logic de, output logic [7:0] got);
        push(4'h0, 1'b0, 1'b1);
        repeat (40) if (colour_index !== 8'h00) @(negedge clk);
        `CHK("blank colour", 8'h00, colour_index)
        // nine equal dots fill the eight-dot pan delay, then the last one drains
        repeat (9) push(p, de, 1'b0);
        repeat (2) @(negedge clk);
        got = colour_index;
    endtask

    // every indexed register reads zero after reset
    task automatic t_reset();
        for (int r = 0; r < 21; r++) begin
            get_reg(5'(r), v);
            `CHK("reset value", 8'h00, v)
        end
    endtask
    // write every register and read it back; reserved index ignored
    task automatic t_regs();
        for (int i = 0; i < 16; i++) set_reg(5'(i), pal(i));
        for (int r = 0; r < 5; r++) set_reg(attr_pkg::IDX_MODE + 5'(r), RV[r]);
        set_reg(5'h15, 8'hFF);
        for (int i = 0; i < 16; i++) begin
            get_reg(5'(i), v);
            `CHK("palette entry", pal(i), v)
        end
        for (int r = 0; r < 5; r++) begin
            get_reg(attr_pkg::IDX_MODE + 5'(r), v);
            `CHK("control register", RV[r], v)
        end
        get_reg(5'h15, v);
        `CHK("reserved index", 8'h00, v)
    endtask
    // flip-flop: status reads clear it, data reads leave it alone
    task automatic t_toggle();
        io_r(attr_pkg::PORT_STAT_MONO, v);
        io_w(attr_pkg::PORT_ATTR_WR, 8'h34);
        io_r(attr_pkg::PORT_ATTR_RD, v);
        io_w(attr_pkg::PORT_ATTR_WR, 8'h03);
        io_w(attr_pkg::PORT_ATTR_WR, 8'h31);
        io_r(attr_pkg::PORT_ATTR_WR, v);
        `CHK("index after pair", 8'h31, v)
        io_r(attr_pkg::PORT_STAT_MONO, v);
        io_w(attr_pkg::PORT_ATTR_WR, 8'h33);
        io_r(attr_pkg::PORT_ATTR_WR, v);
        `CHK("index after status read", 8'h33, v)
        get_reg(attr_pkg::IDX_CSEL, v);
        `CHK("data write after data read", 8'h03, v)
    endtask
    // dot path: palette, source bit, plane gates, upper bits, border, status
    task automatic t_pixels();
        set_reg(attr_pkg::IDX_MODE, 8'h01);
        set_reg(attr_pkg::IDX_PLANE, 8'h0F);
        set_reg(attr_pkg::IDX_PAN, 8'h00);
        set_reg(attr_pkg::IDX_CSEL, 8'h08);
        for (int i = 0; i < 16; i++) begin
            show(4'(i), 1'b1, v);
            `CHK("palette colour", 8'h80 | pal(i), v)
        end
        io_r(attr_pkg::PORT_STAT_MONO, v);
        io_w(attr_pkg::PORT_ATTR_WR, 8'h00);
        show(4'h5, 1'b1, v);
        `CHK("palette blocked", 8'h80, v)
        io_r(attr_pkg::PORT_STAT_MONO, v);
        io_w(attr_pkg::PORT_ATTR_WR, 8'h20);
        set_reg(attr_pkg::IDX_PLANE, 8'h05);
        show(4'hF, 1'b1, v);
        `CHK("plane gating", 8'h9A, v)
        set_reg(attr_pkg::IDX_PLANE, 8'h0F);
        set_reg(attr_pkg::IDX_MODE, 8'h81);
        set_reg(attr_pkg::IDX_CSEL, 8'h0B);
        show(4'h6, 1'b1, v);
        `CHK("colour select bits", 8'hBC, v)
        set_reg(attr_pkg::IDX_BORDER, 8'h5A);
        show(4'h0, 1'b0, v);
        `CHK("border colour", 8'h5A, v)
        for (int s = 0; s < 4; s++) begin
            set_reg(attr_pkg::IDX_PLANE, {2'b00, 2'(s), 4'hF});
            push(4'h0, 1'b0, 1'b0);
            repeat (3) @(negedge clk);
            `CHK("status colour bits", ST[s], status_colour)
        end
    endtask
    // sixteen dots valued 0..15 back to back; output is dot 7 plus the pan shift
    task automatic ramp(input logic [7:0] m, input logic [3:0] pv, output logic [7:0] got);
        set_reg(attr_pkg::IDX_MODE, m);
        set_reg(attr_pkg::IDX_PAN, {4'h0, pv});
        for (int j = 0; j < 16; j++) begin
            @(posedge clk);
            dot_in    <= '{planes: 4'(j), char_code: 8'h00, attr: {4'(j), 4'h0}, fg: 1'b0,
                           dot9: 1'b0, de: 1'b1, blank: 1'b0};
            dot_valid <= 1'b1;
        end
        @(posedge clk);
        dot_valid <= 1'b0;
        repeat (2) @(negedge clk);
        got = colour_index;
    endtask
    // pan steps per mode, compare override until vsync, wide pairing
    task automatic t_pan();
        set_reg(attr_pkg::IDX_CSEL, 8'h08);
        ramp(8'h01, 4'h3, v);
        `CHK("pan graphics", 8'h80 | pal(10), v)
        ramp(8'h02, 4'h3, v);
        `CHK("pan nine-dot", 8'h80 | pal(11), v)
        ramp(8'h02, 4'h8, v);
        `CHK("pan nine-dot eight", 8'h80 | pal(7), v)
        set_reg(attr_pkg::IDX_MODE, 8'h21);
        @(posedge clk) line_compare <= 1'b1;
        @(posedge clk) line_compare <= 1'b0;
        ramp(8'h21, 4'h3, v);
        `CHK("pan after compare", 8'h80 | pal(7), v)
        @(posedge clk) vsync <= 1'b1;
        @(posedge clk) vsync <= 1'b0;
        ramp(8'h21, 4'h3, v);
        `CHK("pan after vsync", 8'h80 | pal(10), v)
        // wide: shift 3, dots 9 then 10, first of the pair is the high nibble
        ramp(8'h41, 4'h6, v);
        `CHK("wide pair", 8'h24, v)
    endtask
    // dac ports are routed to the external device as strobes
    task automatic t_dac();
        io_w(attr_pkg::PORT_DAC_HI, 8'h3C);
        repeat (3) @(negedge clk);
        `CHK("dac writes", 8'h01, wr_count)
        `CHK("dac write data", 8'h3C, last_data)
        `CHK("dac write select", 2'b11, last_sel)
        io_r(attr_pkg::PORT_DAC_LO + 16'h0001, v);
        repeat (3) @(negedge clk);
        `CHK("dac reads", 8'h01, rd_count)
        `CHK("dac read select", 2'b01, last_sel)
        `CHK("long strobes", 8'h00, long_pulses)
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_toggle();
        t_pixels();
        t_pan();
        t_dac();
        summarize();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
